//--- core/cecs_sequencer.sv
// Camera exposure cycle sequencer with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module cecs_sequencer #(
	parameter int unsigned TICK_CYCLES = cecs_pkg::TICK_CYCLES // Clocks per millisecond
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	output cecs_pkg::cecs_cam_t camOut,
	output logic motorRun,
	output logic motorMove,
	output logic startDelayPending
);
	import cecs_pkg::*;

	// ==========================================================
	// Declarations
	logic [31:0] tickCnt_r; // Millisecond prescaler
	logic tick; // One-cycle millisecond strobe
	cecs_cfg_t cfgLive_r; // Software-written timing set
	cecs_cfg_t cfgSnap_r; // Timing set used by the running cycle
	cecs_cfg_t cfgUse; // Set seen at a cycle start
	logic runBit_r; // Program on/off
	logic [15:0] maxShots_r; // Shot limit, zero disables
	logic [15:0] startDelayMin_r; // Start delay in minutes
	cecs_state_t state_r;
	cecs_state_t stateNxt;
	logic [31:0] phaseMs_r; // Time spent in current phase
	logic [31:0] cycleMs_r; // Time since cycle trigger
	logic [31:0] pendLeft_r; // Remaining start delay in ms
	logic [7:0] repeatLeft_r; // Extra shots left this interval
	logic [15:0] shotCount_r; // Exposures taken
	logic [31:0] phaseDur; // Duration of current phase
	logic phaseDone;
	logic startCycle; // A new interval begins at next edge
	logic limitStop; // Shot limit reached
	logic intervalOver;
	logic waitReq_r;
	logic [31:0] readData_r;
	cecs_cam_t camOut_r;
	logic motorRun_r;
	logic motorMove_r;
	logic pending_r;
	logic busAccept; // Write takes effect at this edge
	logic busLatch; // Read data captured at this edge

	// ==========================================================
	// Functions
	// Byte-lane merge of write data into an old word
	function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal, input logic [31:0] newVal,
			input logic [3:0] be);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = newVal[i*8 +: 8];
			end
		end
		return res;
	endfunction : mergeBytes

	// Length of a phase for a given timing set
	function automatic logic [31:0] durOf(input cecs_state_t st, input cecs_cfg_t c);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (st)
			ST_FOCUS: begin
				d = c.focusMs; // Milliseconds, zero means no focus
			end
			ST_EXPOSE: begin
				d = c.bulbMode ? c.exposeMs : FIXED_PHASE_MS;
			end
			ST_DELAY: begin
				d = c.bulbMode ? FIXED_PHASE_MS : c.delayMs;
			end
			ST_MOVE: begin
				d = c.moveBetweenShotsMode ? c.moveMs : 32'h0000_0000;
			end
			default: begin
				d = 32'h0000_0000;
			end
		endcase
		return d;
	endfunction : durOf

	// ==========================================================
	// Millisecond time base shared by every phase and the interval
	// Restarted at each phase change so no phase runs short; the interval loses one cycle per change
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tickCnt_r <= 32'h0000_0000;
		end else if ((tickCnt_r >= TICK_CYCLES - 1) || (stateNxt != state_r)) begin
			tickCnt_r <= 32'h0000_0000; // Wrap, or align to the new phase
		end else begin
			tickCnt_r <= tickCnt_r + 32'h0000_0001;
		end
	end
	assign tick = (tickCnt_r >= TICK_CYCLES - 1);

	// ==========================================================
	// Sequencer next state
	assign cfgUse = cfgLive_r;
	assign phaseDur = durOf(state_r, cfgSnap_r);
	assign phaseDone = (phaseMs_r >= phaseDur);
	// Interval in tenths turned into milliseconds; an overrun starts the next shot at once
	assign intervalOver = (cycleMs_r >= 32'(cfgSnap_r.intervalTenths) * MS_PER_TENTH);
	assign limitStop = (maxShots_r != 16'h0000) && (shotCount_r >= maxShots_r);

	// Shot cycle order and stop handling
	always_comb begin
		stateNxt = state_r;
		startCycle = 1'b0;
		if (!runBit_r) begin
			stateNxt = ST_IDLE; // Switching off aborts at once
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (startDelayMin_r != 16'h0000) begin
						stateNxt = ST_PEND;
					end else begin
						stateNxt = ST_FOCUS;
						startCycle = 1'b1;
					end
				end
				ST_PEND: begin
					if (pendLeft_r == 32'h0000_0000) begin
						stateNxt = ST_FOCUS;
						startCycle = 1'b1;
					end
				end
				ST_FOCUS: begin
					if (phaseDone) begin
						stateNxt = ST_EXPOSE;
					end
				end
				ST_EXPOSE: begin
					if (phaseDone) begin
						stateNxt = ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (phaseDone) begin
						if (limitStop) begin
							stateNxt = ST_IDLE;
						end else if (repeatLeft_r != 8'h00) begin
							stateNxt = ST_FOCUS;
						end else begin
							stateNxt = ST_MOVE; // Move slot only after delay
						end
					end
				end
				ST_MOVE: begin
					if (phaseDone) begin
						if (intervalOver) begin
							stateNxt = ST_FOCUS; // Interval stretched to fit
							startCycle = 1'b1;
						end else begin
							stateNxt = ST_WAIT; // Remaining interval after move
						end
					end
				end
				ST_WAIT: begin
					if (intervalOver) begin
						stateNxt = ST_FOCUS; // Next trigger
						startCycle = 1'b1;
					end
				end
				default: begin
					stateNxt = ST_IDLE;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= stateNxt;
		end
	end

	// Timing set frozen per cycle so edits land on the next shot cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgSnap_r <= '0;
		end else if (startCycle) begin
			cfgSnap_r <= cfgUse;
		end
	end

	// Phase and interval millisecond counters
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			phaseMs_r <= 32'h0000_0000;
			cycleMs_r <= 32'h0000_0000;
		end else begin
			if (stateNxt != state_r) begin
				phaseMs_r <= 32'h0000_0000;
			end else if (tick) begin
				phaseMs_r <= phaseMs_r + 32'h0000_0001;
			end
			if (startCycle) begin
				cycleMs_r <= 32'h0000_0000;
			end else if (tick && (state_r != ST_IDLE) && (state_r != ST_PEND)) begin
				cycleMs_r <= cycleMs_r + 32'h0000_0001;
			end
		end
	end

	// Start delay countdown in milliseconds
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pendLeft_r <= 32'h0000_0000;
		end else if (state_r == ST_IDLE && stateNxt == ST_PEND) begin
			pendLeft_r <= 32'(startDelayMin_r) * MS_PER_MINUTE;
		end else if (state_r == ST_PEND && tick && pendLeft_r != 32'h0000_0000) begin
			pendLeft_r <= pendLeft_r - 32'h0000_0001;
		end
	end

	// Repeat shots left in this interval
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			repeatLeft_r <= 8'h00;
		end else if (startCycle) begin
			repeatLeft_r <= cfgUse.repeatCount;
		end else if (state_r == ST_DELAY && stateNxt == ST_FOCUS) begin
			repeatLeft_r <= repeatLeft_r - 8'h01;
		end
	end

	// Exposure counter, cleared when a program starts
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shotCount_r <= 16'h0000;
		end else if (state_r == ST_IDLE && runBit_r) begin
			shotCount_r <= 16'h0000;
		end else if (stateNxt == ST_EXPOSE && state_r != ST_EXPOSE) begin
			shotCount_r <= shotCount_r + 16'h0001;
		end
	end

	// ==========================================================
	// Registered outputs, decoded from the next state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			camOut_r <= '0;
			motorRun_r <= 1'b0;
			motorMove_r <= 1'b0;
			pending_r <= 1'b0;
		end else begin
			// Focus only with a nonzero focus time, or with shutter when locked
			camOut_r.focus <= (stateNxt == ST_FOCUS && durOf(ST_FOCUS, startCycle ? cfgUse : cfgSnap_r) != 32'h0) ||
				(stateNxt == ST_EXPOSE && cfgSnap_r.focusLock);
			camOut_r.shutter <= (stateNxt == ST_EXPOSE); // Held whole phase, delay keeps it off
			// Continuous motion runs through every phase, delay included
			motorRun_r <= runBit_r && (stateNxt != ST_IDLE) && (stateNxt != ST_PEND) &&
				!cfgLive_r.moveBetweenShotsMode;
			motorMove_r <= (stateNxt == ST_MOVE) && cfgSnap_r.moveBetweenShotsMode;
			pending_r <= (stateNxt == ST_PEND);
		end
	end
	assign camOut = camOut_r;
	assign motorRun = motorRun_r;
	assign motorMove = motorMove_r;
	assign startDelayPending = pending_r;

	// ==========================================================
	// Avalon-MM slave: one wait cycle, then answer
	assign busLatch = (avsRead || avsWrite) && waitReq_r;
	assign busAccept = (avsRead || avsWrite) && !waitReq_r;

	// Waitrequest drops for exactly one cycle per request
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			waitReq_r <= 1'b1;
		end else begin
			waitReq_r <= !busLatch;
		end
	end
	assign avsWaitRequest = waitReq_r;

	// Read mux, unmapped addresses read zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			readData_r <= 32'h0000_0000;
		end else if (busLatch && avsRead) begin
			case (avsAddress)
				OFS_CTRL: readData_r <= {28'h0, cfgLive_r.focusLock, cfgLive_r.moveBetweenShotsMode,
					cfgLive_r.bulbMode, runBit_r};
				OFS_INTERVAL: readData_r <= {16'h0, cfgLive_r.intervalTenths};
				OFS_FOCUS: readData_r <= cfgLive_r.focusMs;
				OFS_EXPOSE: readData_r <= cfgLive_r.exposeMs;
				OFS_DELAY: readData_r <= cfgLive_r.delayMs;
				OFS_MOVE: readData_r <= cfgLive_r.moveMs;
				OFS_REPEAT: readData_r <= {24'h0, cfgLive_r.repeatCount};
				OFS_MAXSHOTS: readData_r <= {16'h0, maxShots_r};
				OFS_STARTDLY: readData_r <= {16'h0, startDelayMin_r};
				OFS_STATUS: readData_r <= {24'h0, camOut_r.shutter, camOut_r.focus, pending_r,
					runBit_r, 1'b0, state_r};
				OFS_SHOTCNT: readData_r <= {16'h0, shotCount_r};
				OFS_PENDLEFT: readData_r <= pendLeft_r;
				default: readData_r <= 32'h0000_0000;
			endcase
		end
	end
	assign avsReadData = readData_r;

	// Software-written settings; a software write beats the automatic stop in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			runBit_r <= CTRL_RESET[CTRL_RUN_BIT];
			cfgLive_r.bulbMode <= CTRL_RESET[CTRL_BULB_BIT];
			cfgLive_r.moveBetweenShotsMode <= CTRL_RESET[CTRL_SMS_BIT];
			cfgLive_r.focusLock <= CTRL_RESET[CTRL_FLOCK_BIT]; // On after reset
			cfgLive_r.intervalTenths <= INTERVAL_RESET;
			cfgLive_r.focusMs <= 32'h0000_0000;
			cfgLive_r.exposeMs <= EXPOSE_RESET;
			cfgLive_r.delayMs <= DELAY_RESET;
			cfgLive_r.moveMs <= 32'h0000_0000;
			cfgLive_r.repeatCount <= 8'h00;
			maxShots_r <= 16'h0000;
			startDelayMin_r <= 16'h0000;
		end else if (busAccept && avsWrite) begin
			case (avsAddress)
				OFS_CTRL: begin
					if (avsByteEnable[0]) begin
						runBit_r <= avsWriteData[CTRL_RUN_BIT];
						// Motion mode is only changeable while stopped
						if (!runBit_r) begin
							cfgLive_r.moveBetweenShotsMode <= avsWriteData[CTRL_SMS_BIT];
						end
						cfgLive_r.bulbMode <= avsWriteData[CTRL_BULB_BIT];
						cfgLive_r.focusLock <= avsWriteData[CTRL_FLOCK_BIT];
					end
				end
				OFS_INTERVAL: cfgLive_r.intervalTenths <= 16'(mergeBytes({16'h0, cfgLive_r.intervalTenths},
					avsWriteData, avsByteEnable));
				OFS_FOCUS: cfgLive_r.focusMs <= mergeBytes(cfgLive_r.focusMs, avsWriteData, avsByteEnable);
				OFS_EXPOSE: cfgLive_r.exposeMs <= mergeBytes(cfgLive_r.exposeMs, avsWriteData, avsByteEnable);
				OFS_DELAY: cfgLive_r.delayMs <= mergeBytes(cfgLive_r.delayMs, avsWriteData, avsByteEnable);
				OFS_MOVE: cfgLive_r.moveMs <= mergeBytes(cfgLive_r.moveMs, avsWriteData, avsByteEnable);
				OFS_REPEAT: cfgLive_r.repeatCount <= 8'(mergeBytes({24'h0, cfgLive_r.repeatCount},
					avsWriteData, avsByteEnable));
				OFS_MAXSHOTS: maxShots_r <= 16'(mergeBytes({16'h0, maxShots_r}, avsWriteData, avsByteEnable));
				OFS_STARTDLY: startDelayMin_r <= 16'(mergeBytes({16'h0, startDelayMin_r},
					avsWriteData, avsByteEnable));
				default: begin
					// Read-only or unmapped: write ignored
				end
			endcase
		end else if (state_r == ST_DELAY && phaseDone && limitStop && runBit_r) begin
			runBit_r <= 1'b0; // Automatic stop at the shot limit
		end
	end

endmodule : cecs_sequencer
`default_nettype wire

//--- core/cecs_pkg.sv
// Constants, types and register map of the camera exposure cycle sequencer
// Contract
// - Trigger runs focus, expose, delay, move, repeat
// - Focus asserted for set time; zero skips
// - Shutter on; camera mode quarter second, bulb user
// - Delay keeps outputs off; bulb uses quarter second
// - Continuous mode motors keep running through delay
// - Move-between-shots moves only after delay ends
// - Phase sum is minimum interval; rest waited after
// - Overlong phases stretch the interval automatically
// - Bulb holds shutter whole exposure time
// - Focus time held in milliseconds
// - Repeat count adds extra shots; zero single
// - Focus-with-shutter option, enabled after reset
// - Nonzero shot limit stops program automatically
// - Start delay minutes: pending countdown before shooting
// - Interval set in tenths of a second
// - Timing changes apply from next cycle
package cecs_pkg;

	// ==========================================================
	// Time base
	localparam int unsigned CLK_FREQ_HZ = 20_000_000; // Core clock rate
	localparam int unsigned TICK_PERIOD_US = 1000; // One millisecond tick
	localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;
	localparam logic [31:0] FIXED_PHASE_MS = 32'h0000_00FA; // Quarter second, 250 ms
	localparam logic [31:0] MS_PER_TENTH = 32'h0000_0064; // 100 ms per interval unit
	localparam logic [31:0] MS_PER_MINUTE = 32'h0000_EA60; // 60000 ms per minute

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INTERVAL = 8'h04;
	localparam logic [7:0] OFS_FOCUS = 8'h08;
	localparam logic [7:0] OFS_EXPOSE = 8'h0C;
	localparam logic [7:0] OFS_DELAY = 8'h10;
	localparam logic [7:0] OFS_MOVE = 8'h14;
	localparam logic [7:0] OFS_REPEAT = 8'h18;
	localparam logic [7:0] OFS_MAXSHOTS = 8'h1C;
	localparam logic [7:0] OFS_STARTDLY = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_SHOTCNT = 8'h28;
	localparam logic [7:0] OFS_PENDLEFT = 8'h2C;

	// ==========================================================
	// Control field positions and reset values
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned CTRL_BULB_BIT = 1;
	localparam int unsigned CTRL_SMS_BIT = 2;
	localparam int unsigned CTRL_FLOCK_BIT = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0008; // Focus lock on by default
	localparam logic [15:0] INTERVAL_RESET = 16'h000A; // One second
	localparam logic [31:0] EXPOSE_RESET = 32'h0000_00C8; // 200 ms
	localparam logic [31:0] DELAY_RESET = 32'h0000_00C8; // 200 ms

	// ==========================================================
	// Sequencer states, Gray coded along the shot path
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PEND = 3'h1,
		ST_FOCUS = 3'h3,
		ST_EXPOSE = 3'h2,
		ST_DELAY = 3'h6,
		ST_MOVE = 3'h7,
		ST_WAIT = 3'h5
	} cecs_state_t;

	// Camera remote port lines
	typedef struct packed {
		logic focus;
		logic shutter;
	} cecs_cam_t;

	// Timing set captured per shot cycle
	typedef struct packed {
		logic bulbMode;
		logic moveBetweenShotsMode;
		logic focusLock;
		logic [15:0] intervalTenths;
		logic [31:0] focusMs;
		logic [31:0] exposeMs;
		logic [31:0] delayMs;
		logic [31:0] moveMs;
		logic [7:0] repeatCount;
	} cecs_cfg_t;

endpackage : cecs_pkg

//--- bench/cecs_sequencer_chk.sv
// Concurrent checker of the sequencer's bus handshake and camera port behaviour
`timescale 1ns/1ps
`default_nettype none
module cecs_sequencer_chk #(
	parameter int unsigned TICK_CYCLES = 4 // Clocks per millisecond, handed on from the design
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsReadData,
	input wire logic avsWaitRequest,
	input wire cecs_pkg::cecs_cam_t camOut,
	input wire logic motorRun,
	input wire logic motorMove,
	input wire logic startDelayPending
);
	import cecs_pkg::*;

	// ==========================================================
	// Common clocking; every check is muted while reset is low
	default clocking cbClk @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// Bus handshake steps
	sequence sBusReq; // Request waiting to be taken
		(avsRead || avsWrite) && avsWaitRequest;
	endsequence
	sequence sBusAnswer; // One answer cycle, then back to waiting
		!avsWaitRequest ##1 avsWaitRequest;
	endsequence

	a_bus_answer: assert property (sBusReq |=> sBusAnswer)
		else $error("bus answer not exactly one cycle after request");
	a_bus_idle: assert property (!(avsRead || avsWrite) && avsWaitRequest |=> avsWaitRequest)
		else $error("waitrequest dropped without a request");
	a_read_hold: assert property (!avsRead |=> $stable(avsReadData))
		else $error("read data changed without a read");

	// ==========================================================
	// Camera and motor relations
	a_move_quiet: assert property (motorMove |-> !camOut.focus && !camOut.shutter)
		else $error("motor moving while a camera line is active");
	a_move_after_delay: assert property ($rose(motorMove) |-> !$past(camOut.shutter))
		else $error("move started straight out of the exposure");
	a_shutter_min: assert property ($rose(camOut.shutter) |=> camOut.shutter [*3])
		else $error("shutter pulse shorter than one millisecond tick");
	a_pend_quiet: assert property (startDelayPending |-> camOut == 2'h0 && !motorMove && !motorRun)
		else $error("activity while the start countdown runs");
	a_motor_excl: assert property (!(motorRun && motorMove))
		else $error("continuous and move slot motor drive together");
endmodule : cecs_sequencer_chk

bind cecs_sequencer cecs_sequencer_chk #(.TICK_CYCLES(TICK_CYCLES)) uChk (
	.core_clk(core_clk), .rst_n(rst_n), .avsRead(avsRead), .avsWrite(avsWrite), .avsReadData(avsReadData),
	.avsWaitRequest(avsWaitRequest), .camOut(camOut), .motorRun(motorRun), .motorMove(motorMove),
	.startDelayPending(startDelayPending)
);
`default_nettype wire

//--- bench/cecs_camera_model.sv
// Behavioural camera on the remote port: it only listens and measures the line timing
`timescale 1ns/1ps
`default_nettype none
module cecs_camera_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire cecs_pkg::cecs_cam_t camOut,
	input wire logic motorMove,
	output int pulses,
	output int shutterLen,
	output int focusLead,
	output int period,
	output int moveLen,
	output int lockCycles
);
	import cecs_pkg::*;
	int hiCnt; // Cycles of the current shutter pulse
	int fCnt; // Focus cycles before the shutter rises
	int perCnt; // Cycles since the last shutter rise
	int mvCnt; // Cycles of the current move slot
	int lockCnt; // Focus cycles inside the shutter pulse
	logic prevShut; // Shutter one cycle ago
	logic prevMove; // Move one cycle ago

	// ==========================================================
	// Measurement; a real camera drives nothing back, so neither does this
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			{pulses, shutterLen, focusLead, period, moveLen, lockCycles} = '0;
			{hiCnt, fCnt, perCnt, mvCnt, lockCnt} = '0;
			prevShut = 1'b0;
			prevMove = 1'b0;
		end else begin
			perCnt++;
			if (camOut.shutter) begin
				// Rising edge latches lead time and shot spacing
				if (!prevShut) begin
					pulses++;
					focusLead = fCnt;
					period = perCnt;
					{perCnt, hiCnt, lockCnt, fCnt} = {32'sd1, 96'h0};
				end
				hiCnt++;
				if (camOut.focus) lockCnt++;
			end else begin
				if (prevShut) begin
					shutterLen = hiCnt;
					lockCycles = lockCnt;
				end
				fCnt = camOut.focus ? fCnt + 1 : 0;
			end
			if (motorMove) begin
				mvCnt++;
			end else if (prevMove) begin
				moveLen = mvCnt;
				mvCnt = 0;
			end
			prevShut = camOut.shutter;
			prevMove = motorMove;
		end
	end
endmodule : cecs_camera_model
`default_nettype wire

//--- bench/tb_camera_exposure_cycle_sequencer.sv
// Self-checking bench of the sequencer: register access, shot timing, shot limit, start countdown
`timescale 1ns/1ps
`default_nettype none
module tb_camera_exposure_cycle_sequencer;
	import cecs_pkg::*;
	localparam int TICK = 4; // Short millisecond keeps the run brief
	localparam int LIMIT = 30000; // Cycle ceiling for the whole run
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avsAddress = 8'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h0;
	logic [3:0] avsByteEnable = 4'hF;
	logic [31:0] avsReadData;
	logic avsWaitRequest;
	cecs_cam_t camOut;
	logic motorRun;
	logic motorMove;
	logic startDelayPending;
	int pulses, shutterLen, focusLead, period, moveLen, lockCycles; // Camera measurements
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] rd; // Last read word
	logic [7:0] rstAdr [10] = '{OFS_CTRL, OFS_INTERVAL, OFS_FOCUS, OFS_EXPOSE, OFS_DELAY, OFS_MOVE,
		OFS_REPEAT, OFS_MAXSHOTS, OFS_STARTDLY, 8'h3C};
	logic [31:0] rstVal [10] = '{CTRL_RESET, 32'h0000_000A, 32'h0, EXPOSE_RESET, DELAY_RESET, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h0};
	int iv [2] = '{5, 1}; // Interval settings in tenths: one waits, one overruns
	int p0; // Pulse count before a scenario
	int expPer; // Expected shot spacing in cycles

	// ==========================================================
	// Clock, design and camera
	always #25 core_clk = ~core_clk;
	cecs_sequencer #(.TICK_CYCLES(TICK)) DUT (
		.core_clk(core_clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .camOut(camOut), .motorRun(motorRun), .motorMove(motorMove),
		.startDelayPending(startDelayPending)
	);
	cecs_camera_model uCam (
		.core_clk(core_clk), .rst_n(rst_n), .camOut(camOut), .motorMove(motorMove), .pulses(pulses),
		.shutterLen(shutterLen), .focusLead(focusLead), .period(period), .moveLen(moveLen),
		.lockCycles(lockCycles)
	);

	// ==========================================================
	// Helpers
	task wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	// Avalon write; request held until waitrequest is sampled low
	task bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= 1'b1;
		do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
		avsWrite <= 1'b0;
	endtask : bus_wr

	// Avalon read; data taken at the edge that sees waitrequest low
	task bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		avsAddress <= a;
		avsRead <= 1'b1;
		do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
		d = avsReadData;
		avsRead <= 1'b0;
	endtask : bus_rd

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
			fail_count++;
		end
	endtask : chk

	// Measured figures have a tick of slack per phase
	task chk_rng(input int v, input int lo, input int hi);
		tests_run++;
		if (v < lo || v > hi) begin
			$display("wrong value at %0t: got %0h expected %0h to %0h", $time, v, lo, hi);
			fail_count++;
		end
	endtask : chk_rng

	// Poll the run bit until the shot limit clears it
	task wait_stop;
		rd = 32'h10;
		while (rd[4] !== 1'b0) begin
			repeat (50) @(posedge core_clk);
			bus_rd(OFS_STATUS, rd);
		end
	endtask : wait_stop

	// Timeout guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles >= LIMIT) begin
			fail_count++;
			wrap_up();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		// Reset values, including an unmapped place
		for (int i = 0; i < 10; i++) begin
			bus_rd(rstAdr[i], rd);
			chk(rd, rstVal[i]);
		end
		// Counter is read-only
		bus_wr(OFS_SHOTCNT, 32'h0000_0055);
		bus_rd(OFS_SHOTCNT, rd);
		chk(rd, 32'h0);
		// Camera timed, move between shots, focus lock, waiting and overrun intervals
		bus_wr(OFS_FOCUS, 32'h5);
		bus_wr(OFS_DELAY, 32'hA);
		bus_wr(OFS_MOVE, 32'hA);
		bus_wr(OFS_MAXSHOTS, 32'h2);
		for (int k = 0; k < 2; k++) begin
			p0 = pulses;
			expPer = (iv[k] * 100 > 275 ? iv[k] * 100 : 275) * TICK;
			bus_wr(OFS_INTERVAL, iv[k]);
			bus_wr(OFS_CTRL, 32'h0000_000C);
			bus_wr(OFS_CTRL, 32'h0000_000D);
			wait_stop();
			chk_rng(shutterLen, 250 * TICK, 250 * TICK + 6);
			chk_rng(focusLead, 5 * TICK, 5 * TICK + 6);
			chk_rng(lockCycles, shutterLen, shutterLen);
			chk_rng(period, expPer - TICK, expPer + 30);
			chk_rng(moveLen, 10 * TICK, 10 * TICK + 6);
			chk_rng(pulses - p0, 2, 2);
			bus_rd(OFS_SHOTCNT, rd);
			chk(rd, 32'h2);
		end
		// Bulb timed, one repeat, continuous motion, no focus lock
		p0 = pulses;
		bus_wr(OFS_FOCUS, 32'h0);
		bus_wr(OFS_EXPOSE, 32'h14);
		bus_wr(OFS_REPEAT, 32'h1);
		bus_wr(OFS_CTRL, 32'h0000_0002);
		bus_wr(OFS_CTRL, 32'h0000_0003);
		repeat (10) @(posedge core_clk);
		chk(motorRun, 1'b1);
		bus_wr(OFS_EXPOSE, 32'h0000_0028);
		wait_stop();
		chk_rng(shutterLen, 20 * TICK, 20 * TICK + 6);
		chk_rng(lockCycles, 0, 0);
		chk_rng(focusLead, 0, 0);
		chk_rng(period, 270 * TICK - TICK, 270 * TICK + 20);
		chk_rng(pulses - p0, 2, 2);
		chk(motorRun, 1'b0);
		// Start countdown, then abort
		p0 = pulses;
		bus_wr(OFS_STARTDLY, 32'h1);
		bus_wr(OFS_CTRL, 32'h0000_0001);
		repeat (400) @(posedge core_clk);
		chk(startDelayPending, 1'b1);
		bus_rd(OFS_PENDLEFT, rd);
		chk_rng(rd, 59895, 59905);
		chk_rng(pulses - p0, 0, 0);
		bus_rd(OFS_STATUS, rd);
		chk(rd, 32'h0000_0031);
		bus_wr(OFS_CTRL, 32'h0000_0005);
		bus_rd(OFS_CTRL, rd);
		chk(rd, 32'h0000_0001);
		bus_wr(OFS_CTRL, 32'h0);
		repeat (3) @(posedge core_clk);
		chk(startDelayPending, 1'b0);
		wrap_up();
	end
endmodule : tb_camera_exposure_cycle_sequencer
`default_nettype wire
